//--- src/autoneg_regs_map.vh
// Register indices, field positions and reset values of the AN page bank
`ifndef AUTONEG_REGS_MAP_VH
`define AUTONEG_REGS_MAP_VH

// ==========================================================================
// Register indices (byte address = index * 4)
`define LP_ABILITY_IDX 16'h2005
`define AN_EXPANSION_IDX 16'h2006
`define NP_TRANSMIT_IDX 16'h2007
`define AN_CONTROL_IDX 16'h2010
`define IRQ_STATUS_IDX 16'h2011
`define IRQ_ENABLE_IDX 16'h2012
`define IRQ_CLEAR_IDX 16'h2013

// ==========================================================================
// Interface modes (control register bits 1:0)
`define MODE_BASEX 2'h0
`define MODE_SGMII_MEDIA 2'h1
`define MODE_SGMII_SYSTEM 2'h2

// ==========================================================================
// Field positions
`define CW_NEXT_PAGE 15
`define CW_ACK 14
`define CW_MSG_PAGE 13
`define CW_ACK2 12
`define CW_TOGGLE 11
`define CTL_AN_ENABLE 4
`define CTL_SOFT_RESET 15
`define EXP_LP_NP_ABLE 3
`define EXP_LOCAL_NP_ABLE 2
`define EXP_PAGE_RX 1
`define EXP_LP_AN_ABLE 0
`define IRQ_PAGE_RX 0
`define IRQ_LINK_DOWN 1
`define IRQ_LP_AN_ABLE 2

// ==========================================================================
// Reset values and counts
`define NP_TRANSMIT_RST 16'h2001
`define AN_CONTROL_RST 16'h0010
`define LOCAL_NP_ABLE_VAL 1'h1
`define CFG_MATCH_COUNT 2'h3

`endif

//--- src/autoneg_partner_page_regs.v
// Auto-negotiation partner page register bank with an AHB-Lite slave port
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "autoneg_regs_map.vh"

// Notes on behaviour
// - Media-side acknowledge clears on link down, loads code word bit 14
// - System-side bit 15 shows partner copper link up
// - System-side bit 12 shows partner duplex, 1 full, 0 half
// - Bits 11:10 give partner speed; clear on link down, load on page
// - Bits 9, 8, 7 give tx pause, rx pause, fiber status
// - System-side bits 6:0 and bit 13 captured as received
// - Partner next-page-able reads 0 in SGMII; set from bit 15 in BASE-X
// - Local next-page-able bit always reads 1
// - Page-received flag latches high on each valid page
// - Partner AN-able needs sync, 3 matching code groups, AN enabled
// - Write to next-page transmit marks next page loaded
// - Next-page loaded flag only sets in 1000BASE-X mode; the word is written in any mode
// - Next page bits 15, 13, 12, 10:0 writable; bit 14 reads 0
// - Transmit toggle bit inverts on every received page

module autoneg_partner_page_regs #(
   parameter DATA_WIDTH = 16
) (
   // Clock, reset, enable
   input wire clk_in,
   input wire reset_in,
   input wire ce_in,
   // AHB-Lite slave
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output reg [31:0] hrdata_out,
   output reg hreadyout_out,
   output reg hresp_out,
   // Receive side of the link logic
   input wire link_up_in,
   input wire sync_status_in,
   input wire page_rx_in,
   input wire page_is_base_in,
   input wire [DATA_WIDTH-1:0] rx_code_word_in,
   input wire cfg_group_valid_in,
   input wire [DATA_WIDTH-1:0] cfg_group_in,
   // Next page handshake with the AN state machine
   input wire np_taken_in,
   output reg [DATA_WIDTH-1:0] np_tx_word_out,
   output reg np_loaded_out,
   output reg [1:0] mode_out,
   output reg an_enable_out,
   // Interrupt
   output reg irq_out
);

   // =======================================================================
   // State
   reg [DATA_WIDTH-1:0] lp_word_reg;
   reg lp_np_able_reg;
   reg page_rx_latched_high_reg;
   reg lp_an_able_reg;
   reg [DATA_WIDTH-1:0] last_cfg_reg;
   reg [1:0] cfg_count_reg;
   reg link_up_d_reg;
   reg [2:0] irq_status_reg;
   reg [2:0] irq_enable_reg;
   reg wr_pending_reg;
   reg [15:0] wr_index_reg;

   wire [15:0] addr_index;
   wire bus_take;
   wire rd_take;
   wire soft_reset;
   wire link_down_evt;
   wire base_page;
   wire [DATA_WIDTH-1:0] ctrl_word;
   wire cfg_nonzero;
   wire cfg_same;
   wire wr_np;
   wire wr_ctrl;
   wire wr_clear;
   wire wr_enable;
   wire rd_expansion;
   wire [2:0] irq_events;
   wire [2:0] irq_status_next;

   reg [DATA_WIDTH-1:0] read_word;
   reg [DATA_WIDTH-1:0] lp_view;
   reg [DATA_WIDTH-1:0] expansion_view;

   // =======================================================================
   // Reset constants
   // Defaults come from the map; only hard reset loads them into control
   wire [15:0] ctrl_rst_word;
   wire an_enable_rst;

   assign ctrl_rst_word = `AN_CONTROL_RST;
   assign an_enable_rst = ctrl_rst_word[`CTL_AN_ENABLE];

   // =======================================================================
   // Bus decode
   // Address index sits above the two byte-lane bits
   assign addr_index = haddr_in[17:2];
   assign bus_take = hsel_in && hready_in && htrans_in[1];
   assign rd_take = bus_take && !hwrite_in;
   assign rd_expansion = rd_take && (addr_index == `AN_EXPANSION_IDX);

   assign wr_np = wr_pending_reg && (wr_index_reg == `NP_TRANSMIT_IDX);
   assign wr_ctrl = wr_pending_reg && (wr_index_reg == `AN_CONTROL_IDX);
   assign wr_clear = wr_pending_reg && (wr_index_reg == `IRQ_CLEAR_IDX);
   assign wr_enable = wr_pending_reg && (wr_index_reg == `IRQ_ENABLE_IDX);

   // Self-clearing soft reset returns capture, latch, ability and next page state to defaults; control and interrupt registers are not reset
   assign soft_reset = wr_ctrl && hwdata_in[`CTL_SOFT_RESET];

   assign ctrl_word = {11'h000, an_enable_out, 2'h0, mode_out};

   // =======================================================================
   // Link events
   assign link_down_evt = link_up_d_reg && !link_up_in;
   assign base_page = page_rx_in && page_is_base_in && link_up_in;
   assign cfg_nonzero = |cfg_group_in;
   assign cfg_same = (cfg_group_in == last_cfg_reg);

   assign irq_events = {(sync_status_in && an_enable_out &&
                         (cfg_count_reg == `CFG_MATCH_COUNT) &&
                         !lp_an_able_reg),
                        link_down_evt, page_rx_in};
   // Set wins over a clear in the same cycle
   assign irq_status_next = (irq_status_reg &
                            ~(wr_clear ? hwdata_in[2:0] : 3'h0)) |
                            irq_events;

   // =======================================================================
   // Read views
   always @* begin
      lp_view = lp_word_reg;
      case (mode_out)
         `MODE_SGMII_MEDIA: begin
            // Bit 15 is fixed at zero; 13:0 shown as the partner sent them
            lp_view = {1'b0, lp_word_reg[`CW_ACK],
                       lp_word_reg[13:0]};
         end
         `MODE_SGMII_SYSTEM: begin
            // Link, ack, bit 13, duplex, speed, pause, fiber, 6:0
            lp_view = lp_word_reg;
         end
         default: begin
            lp_view = lp_word_reg;
         end
      endcase
   end

   always @* begin
      expansion_view = 16'h0000;
      // Partner next page ability is hidden outside BASE-X
      expansion_view[`EXP_LP_NP_ABLE] = lp_np_able_reg &&
                                        (mode_out == `MODE_BASEX);
      expansion_view[`EXP_LOCAL_NP_ABLE] = `LOCAL_NP_ABLE_VAL;
      expansion_view[`EXP_PAGE_RX] = page_rx_latched_high_reg;
      expansion_view[`EXP_LP_AN_ABLE] = lp_an_able_reg;
   end

   always @* begin
      case (addr_index)
         `LP_ABILITY_IDX: begin
            read_word = lp_view;
         end
         `AN_EXPANSION_IDX: begin
            read_word = expansion_view;
         end
         `NP_TRANSMIT_IDX: begin
            read_word = np_tx_word_out;
         end
         `AN_CONTROL_IDX: begin
            read_word = ctrl_word;
         end
         `IRQ_STATUS_IDX: begin
            read_word = {13'h0000, irq_status_reg};
         end
         `IRQ_ENABLE_IDX: begin
            read_word = {13'h0000, irq_enable_reg};
         end
         default: begin
            // Unmapped and write-only addresses read zero
            read_word = 16'h0000;
         end
      endcase
   end

   // =======================================================================
   // Bus slave: zero wait states, always OKAY
   // Transfer size is not decoded; only whole words are expected
   // Read data are fixed at the address phase, one edge early
   always @(posedge clk_in) begin
      if (reset_in) begin
         hrdata_out <= 32'h00000000;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         wr_pending_reg <= 1'b0;
         wr_index_reg <= 16'h0000;
      end else if (ce_in) begin
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         wr_pending_reg <= bus_take && hwrite_in;
         wr_index_reg <= addr_index;
         if (rd_take) begin
            hrdata_out <= {16'h0000, read_word};
         end
      end
   end

   // =======================================================================
   // Control and interrupt registers
   always @(posedge clk_in) begin
      if (reset_in) begin
         mode_out <= `MODE_BASEX;
         an_enable_out <= an_enable_rst;
         irq_status_reg <= 3'h0;
         irq_enable_reg <= 3'h0;
         irq_out <= 1'b0;
      end else if (ce_in) begin
         if (wr_ctrl) begin
            mode_out <= hwdata_in[1:0];
            an_enable_out <= hwdata_in[`CTL_AN_ENABLE];
         end
         if (wr_enable) begin
            irq_enable_reg <= hwdata_in[2:0];
         end
         irq_status_reg <= irq_status_next;
         // Level output tracks the next status so it never lags a clear
         irq_out <= |(irq_status_next &
                      (wr_enable ? hwdata_in[2:0] : irq_enable_reg));
      end
   end

   // =======================================================================
   // Partner ability capture
   always @(posedge clk_in) begin
      if (reset_in || (ce_in && soft_reset)) begin
         lp_word_reg <= 16'h0000;
         lp_np_able_reg <= 1'b0;
         link_up_d_reg <= 1'b0;
      end else if (ce_in) begin
         link_up_d_reg <= link_up_in;
         if (!link_up_in) begin
            // Abilities are stale once the link is gone
            lp_word_reg <= 16'h0000;
            lp_np_able_reg <= 1'b0;
         end else if (base_page) begin
            lp_word_reg <= rx_code_word_in;
            if (mode_out == `MODE_BASEX) begin
               lp_np_able_reg <= rx_code_word_in[`CW_NEXT_PAGE];
            end else begin
               lp_np_able_reg <= 1'b0;
            end
         end
      end
   end

   // =======================================================================
   // Page received latch
   always @(posedge clk_in) begin
      if (reset_in || (ce_in && soft_reset)) begin
         page_rx_latched_high_reg <= 1'b0;
      end else if (ce_in) begin
         // A page in the read cycle survives the clear
         if (page_rx_in) begin
            page_rx_latched_high_reg <= 1'b1;
         end else if (rd_expansion) begin
            page_rx_latched_high_reg <= 1'b0;
         end
      end
   end

   // =======================================================================
   // Partner auto-negotiation ability
   always @(posedge clk_in) begin
      if (reset_in || (ce_in && soft_reset)) begin
         last_cfg_reg <= 16'h0000;
         cfg_count_reg <= 2'h0;
         lp_an_able_reg <= 1'b0;
      end else if (ce_in) begin
         if (!sync_status_in) begin
            cfg_count_reg <= 2'h0;
         end else if (cfg_group_valid_in) begin
            last_cfg_reg <= cfg_group_in;
            if (!cfg_nonzero) begin
               cfg_count_reg <= 2'h0;
            end else if (cfg_same && (cfg_count_reg != 2'h0)) begin
               if (cfg_count_reg != `CFG_MATCH_COUNT) begin
                  cfg_count_reg <= cfg_count_reg + 2'h1;
               end
            end else begin
               cfg_count_reg <= 2'h1;
            end
         end
         lp_an_able_reg <= sync_status_in && an_enable_out &&
                           (cfg_count_reg == `CFG_MATCH_COUNT);
      end
   end

   // =======================================================================
   // Next page transmit
   always @(posedge clk_in) begin
      if (reset_in || (ce_in && soft_reset)) begin
         np_tx_word_out <= `NP_TRANSMIT_RST;
         np_loaded_out <= 1'b0;
      end else if (ce_in) begin
         if (wr_np) begin
            np_tx_word_out[`CW_NEXT_PAGE] <= hwdata_in[`CW_NEXT_PAGE];
            np_tx_word_out[`CW_MSG_PAGE] <= hwdata_in[`CW_MSG_PAGE];
            np_tx_word_out[`CW_ACK2] <= hwdata_in[`CW_ACK2];
            np_tx_word_out[10:0] <= hwdata_in[10:0];
         end
         // Bit 14 is never written and stays zero
         np_tx_word_out[`CW_ACK] <= 1'b0;
         if (page_rx_in) begin
            np_tx_word_out[`CW_TOGGLE] <= ~np_tx_word_out[`CW_TOGGLE];
         end
         // Loaded flag only steers the state machine in BASE-X
         if (wr_np && (mode_out == `MODE_BASEX)) begin
            np_loaded_out <= 1'b1;
         end else if (np_taken_in || (mode_out != `MODE_BASEX)) begin
            np_loaded_out <= 1'b0;
         end
      end
   end

endmodule

//--- testbench/autoneg_partner_page_regs_assertions.sv
// Port checks for the AN partner page register bank
`timescale 1ns/1ps
`include "autoneg_regs_map.vh"
module autoneg_checker #(
   parameter DATA_WIDTH = 16
) (
   // Clock and reset
   input wire clk_in,
   input wire reset_in,
   // Bus
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire hready_in,
   input wire [31:0] hrdata_out,
   // Link and next page
   input wire link_up_in,
   input wire page_rx_in,
   input wire page_is_base_in,
   input wire [DATA_WIDTH-1:0] rx_code_word_in,
   input wire [DATA_WIDTH-1:0] np_tx_word_out,
   input wire np_loaded_out,
   input wire [1:0] mode_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // ==========================================================
   // Decode
   wire xfer = hsel_in && htrans_in[1] && hready_in;
   wire [15:0] idx = haddr_in[17:2];
   wire rd_lp = xfer && !hwrite_in && idx == `LP_ABILITY_IDX;
   wire rd_exp = xfer && !hwrite_in && idx == `AN_EXPANSION_IDX;
   wire wr_np = xfer && hwrite_in && idx == `NP_TRANSMIT_IDX;
   sequence s_sys_page;
      page_rx_in && page_is_base_in && link_up_in
         && mode_out == `MODE_SGMII_SYSTEM ##1 rd_lp && link_up_in;
   endsequence
   // Gap of one cycle, so the clear of the first read has landed
   sequence s_two_reads;
      rd_exp && !page_rx_in ##1 !page_rx_in ##1 rd_exp;
   endsequence
   // ==========================================================
   // Assertions
   AST_SYS_VIEW:
      assert property (s_sys_page |=>
         hrdata_out[15:0] == $past(rx_code_word_in, 2))
      else $error("system view differs from code word");
   AST_LINK_CLEAR:
      assert property (!link_up_in ##1 rd_lp && !link_up_in |=>
         hrdata_out == 32'h0)
      else $error("partner view kept after link down");
   AST_LOCAL_NP: assert property (rd_exp |=> hrdata_out[2])
      else $error("local next page able low");
   AST_NP_SGMII:
      assert property (rd_exp && mode_out != `MODE_BASEX |=> !hrdata_out[3])
      else $error("partner next page able set in SGMII");
   AST_PAGE_LATCH:
      assert property (page_rx_in && link_up_in ##1 rd_exp |=> hrdata_out[1])
      else $error("page received flag not set");
   AST_LATCH_CLEAR:
      assert property (s_two_reads |=> !hrdata_out[1])
      else $error("page received flag not cleared by read");
   AST_NP_LOAD:
      assert property (wr_np && mode_out == `MODE_BASEX |-> ##2 np_loaded_out)
      else $error("next page write not marked loaded");
   AST_NP_MODE:
      assert property ((mode_out != `MODE_BASEX) [*2] |-> !np_loaded_out)
      else $error("next page loaded outside BASE-X");
   AST_TOGGLE:
      assert property (page_rx_in |=>
         np_tx_word_out[11] != $past(np_tx_word_out[11]))
      else $error("toggle not inverted on page");
endmodule

bind autoneg_partner_page_regs autoneg_checker #(.DATA_WIDTH(DATA_WIDTH))
   u_autoneg_checker (.clk_in, .reset_in, .hsel_in, .haddr_in, .htrans_in,
   .hwrite_in, .hready_in, .hrdata_out, .link_up_in, .page_rx_in,
   .page_is_base_in, .rx_code_word_in, .np_tx_word_out, .np_loaded_out,
   .mode_out);

//--- testbench/peer_model.sv
// Behavioural remote link partner and next page consumer
`timescale 1ns/1ps
module peer_model (
   // Clock and next page status
   input wire clk_in,
   input wire np_loaded_in,
   // Link lines
   output reg link_up_out = 1'b0,
   output reg sync_out = 1'b0,
   output reg page_out = 1'b0,
   output reg base_out = 1'b0,
   output reg [15:0] word_out = 16'h0,
   output reg cfg_valid_out = 1'b0,
   output reg [15:0] cfg_out = 16'h0,
   output reg taken_out = 1'b0
);
   integer lag = 0;
   integer cnt = 0;
   task set_line(input l, input s);
      begin
         link_up_out <= l;
         sync_out <= s;
      end
   endtask
   // Idle word lines show the inverse, never a stale copy
   task send_page(input b, input [15:0] w);
      begin
         page_out <= 1'b1;
         base_out <= b;
         word_out <= w;
         @(posedge clk_in);
         page_out <= 1'b0;
         word_out <= ~w;
      end
   endtask
   task send_cfg(input [15:0] g, input integer n);
      begin
         repeat (n) begin
            cfg_valid_out <= 1'b1;
            cfg_out <= g;
            @(posedge clk_in);
         end
         cfg_valid_out <= 1'b0;
         cfg_out <= ~g;
      end
   endtask
   // Lag sets prompt or slow take-up of a loaded page
   always @(posedge clk_in) begin
      if (np_loaded_in && !taken_out && cnt >= lag) begin
         taken_out <= 1'b1;
         cnt <= 0;
      end else begin
         taken_out <= 1'b0;
         cnt <= np_loaded_in ? cnt + 1 : 0;
      end
   end
endmodule

//--- testbench/autoneg_partner_page_regs_tb.sv
// Self-checking bench of the AN partner page register bank
`timescale 1ns/1ps
`include "autoneg_regs_map.vh"
module autoneg_partner_page_regs_tb;
   reg clk_in = 1'b0;
   reg reset_in = 1'b1;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0;
   wire [31:0] hrdata;
   wire hready, hresp, link_up, sync, page, base, cfg_v, taken;
   wire np_loaded, irq, an_en;
   wire [15:0] word, cfg, np_word;
   wire [1:0] mode;
   integer seed = 32'h8139F987;
   integer miscompares = 0;
   integer n_tests = 0;
   integer cyc = 0;
   reg [1:0] m;
   reg tgl = 1'b0;
   reg [31:0] w;
   always #10 clk_in = ~clk_in;
   autoneg_partner_page_regs u_autoneg_partner_page_regs (
      .clk_in(clk_in), .reset_in(reset_in), .ce_in(1'b1), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
      .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .link_up_in(link_up), .sync_status_in(sync), .page_rx_in(page),
      .page_is_base_in(base), .rx_code_word_in(word),
      .cfg_group_valid_in(cfg_v), .cfg_group_in(cfg), .np_taken_in(taken),
      .np_tx_word_out(np_word), .np_loaded_out(np_loaded),
      .mode_out(mode), .an_enable_out(an_en), .irq_out(irq));
   peer_model u_peer_model (.clk_in(clk_in), .np_loaded_in(np_loaded),
      .link_up_out(link_up), .sync_out(sync), .page_out(page),
      .base_out(base), .word_out(word), .cfg_valid_out(cfg_v),
      .cfg_out(cfg), .taken_out(taken));
   // ==========================================================
   // Tasks and expectations
   task chk(input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
         end
      end
   endtask
   // Entered and left at a rising edge; zero-wait slave still polled
   task bus(input wr, input [15:0] idx, input [31:0] wd);
      begin
         hsel <= 1'b1;
         htrans <= 2'h2;
         haddr <= {14'h0, idx, 2'h0};
         hwrite <= wr;
         @(posedge clk_in);
         while (hready !== 1'b1) @(posedge clk_in);
         htrans <= 2'h0;
         hwdata <= wd;
         @(posedge clk_in);
         while (hready !== 1'b1) @(posedge clk_in);
      end
   endtask
   task rd(input [15:0] idx, input [31:0] exp);
      begin
         bus(1'b0, idx, 32'h0);
         chk(hrdata, exp);
      end
   endtask
   task tick(input integer n);
      repeat (n) @(posedge clk_in);
   endtask
   task close_out;
      begin
         $display("compares %0d mismatches %0d", n_tests, miscompares);
         if (miscompares == 0 && n_tests > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   function [31:0] exp_np(input [15:0] v, input t);
      exp_np = {16'h0, v[15], 1'b0, v[13:12], t, v[10:0]};
   endfunction
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         miscompares = miscompares + 1;
         close_out;
      end
   end
   // ==========================================================
   // Scenarios
   initial begin
      tick(3);
      reset_in <= 1'b0;
      tick(2);
      chk(np_word, `NP_TRANSMIT_RST);
      chk(hresp, 1'b0);
      chk(an_en, 1'b1);
      chk(mode, 2'h0);
      chk(np_loaded, 1'b0);
      rd(`AN_EXPANSION_IDX, 32'h4);
      rd(16'h3FFF, 32'h0);
      $display("reset test done");
      for (m = 0; m != 3; m = m + 1) begin
         bus(1'b1, `AN_CONTROL_IDX, {30'h4, m});
         u_peer_model.set_line(1'b1, 1'b0);
         w = $random(seed);
         if (m == 1) w[13:0] = 14'h0001;
         u_peer_model.send_page(1'b1, w[15:0]);
         if (m == 1) rd(`LP_ABILITY_IDX, {17'h0, w[14:0]});
         if (m == 2) rd(`LP_ABILITY_IDX, {16'h0, w[15:0]});
         u_peer_model.send_page(1'b1, w[15:0]);
         tgl = ~tgl ^ tgl ^ tgl;
         rd(`AN_EXPANSION_IDX, {m == 0 && w[15], 3'h6});
         rd(`AN_EXPANSION_IDX, {m == 0 && w[15], 3'h4});
         chk(np_word[11], 1'b0);
         u_peer_model.set_line(1'b0, 1'b0);
         tick(1);
         rd(`LP_ABILITY_IDX, 32'h0);
      end
      $display("partner page test done");
      for (m = 0; m != 3; m = m + 1) begin
         u_peer_model.lag = m * 6;
         bus(1'b1, `AN_CONTROL_IDX, {30'h4, 1'b0, m[1]});
         w = $random(seed);
         bus(1'b1, `NP_TRANSMIT_IDX, w);
         tick(1);
         chk(np_loaded, m != 2);
         chk(np_word, exp_np(w[15:0], 1'b0));
         rd(`NP_TRANSMIT_IDX, exp_np(w[15:0], 1'b0));
         while (np_loaded === 1'b1) tick(1);
      end
      bus(1'b1, `AN_CONTROL_IDX, 32'h8000);
      tick(1);
      chk(np_word, `NP_TRANSMIT_RST);
      chk(an_en, 1'b0);
      $display("next page test done");
      bus(1'b1, `AN_CONTROL_IDX, 32'h10);
      u_peer_model.set_line(1'b1, 1'b1);
      w = $random(seed) | 32'h1;
      u_peer_model.send_cfg(w[15:0], 2);
      tick(1);
      u_peer_model.send_cfg(w[15:0] ^ 16'h8000, 1);
      tick(2);
      rd(`AN_EXPANSION_IDX, 32'h4);
      u_peer_model.send_cfg(w[15:0] ^ 16'h8000, 2);
      tick(2);
      rd(`AN_EXPANSION_IDX, 32'h5);
      bus(1'b1, `AN_CONTROL_IDX, 32'h0);
      tick(2);
      chk(an_en, 1'b0);
      rd(`AN_EXPANSION_IDX, 32'h4);
      $display("partner able test done");
      bus(1'b1, `IRQ_CLEAR_IDX, 32'h7);
      bus(1'b1, `IRQ_ENABLE_IDX, 32'h1);
      tick(2);
      chk(irq, 1'b0);
      u_peer_model.send_page(1'b1, 16'h4001);
      tick(2);
      chk(irq, 1'b1);
      rd(`IRQ_STATUS_IDX, 32'h1);
      bus(1'b1, `IRQ_ENABLE_IDX, 32'h0);
      tick(2);
      chk(irq, 1'b0);
      bus(1'b1, `IRQ_ENABLE_IDX, 32'h1);
      bus(1'b1, `IRQ_CLEAR_IDX, 32'h1);
      tick(2);
      chk(irq, 1'b0);
      $display("interrupt test done");
      close_out;
   end
endmodule
